// *** include/dram_core_regs.svh ***
`ifndef DRAM_CORE_REGS_SVH
`define DRAM_CORE_REGS_SVH

// widths
`define ADDR_W              12
`define BANK_W              2
`define BANK_COUNT          4
`define DATA_W              32
`define MASK_W              4
`define BYTE_W              8
`define COL_W               9
`define CNT_W               8
`define MEM_DEPTH           2048

// field positions on the address lines
`define PRECHARGE_MODE_BIT  8
`define COL_HIGH_BIT        9
`define COL_LOW_TOP         7

// mode register targets
`define MODE_SEL_MAIN       2'h0
`define MODE_SEL_EXT        2'h1

// burst
`define BURST_LEN           4

// timing in ns, counts in 100 ns cycles rounded up
`define CLOCK_PERIOD_NS          100
`define ACTIVATE_DELAY_NS        200
`define ROW_PRECHARGE_DELAY_NS   300
`define MIN_ROW_ACTIVE_NS        800
`define MODE_LOAD_DELAY_NS       400
`define SELF_REFRESH_INTERVAL_NS 3900
`define NS_TO_CYCLES(t) (((t) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define ACTIVATE_CYCLES      `NS_TO_CYCLES(`ACTIVATE_DELAY_NS)
`define ROW_PRECHARGE_CYCLES `NS_TO_CYCLES(`ROW_PRECHARGE_DELAY_NS)
`define MIN_ROW_ACTIVE_CYCLES `NS_TO_CYCLES(`MIN_ROW_ACTIVE_NS)
`define MODE_LOAD_CYCLES     `NS_TO_CYCLES(`MODE_LOAD_DELAY_NS)
`define SELF_REFRESH_CYCLES  `NS_TO_CYCLES(`SELF_REFRESH_INTERVAL_NS)

`endif

// *** include/dram_core_pkg.sv ***
package dram_core_pkg;
    `include "dram_core_regs.svh"

    typedef enum {BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_PRECHARGING} bank_state_type;
    typedef enum {CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
                  CMD_REFRESH, CMD_MODE_LOAD} cmd_type;
    typedef enum {BURST_NONE, BURST_READ, BURST_WRITE} burst_type;

    typedef struct packed {
        logic                ck;
        logic                cke;
        logic                csN;
        logic                rasN;
        logic                casN;
        logic                weN;
        logic                bank1;
        logic                bank0;
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  dq;
        logic [`MASK_W-1:0]  mask;
    } pin_sample_type;

    function automatic cmd_type decode_command(input logic csN, input logic rasN,
                                               input logic casN, input logic weN);
        cmd_type c;
        c = CMD_NOP;
        if (!csN) begin
            case ({rasN, casN, weN})
                3'h3: c = CMD_ACTIVATE;
                3'h5: c = CMD_READ;
                3'h4: c = CMD_WRITE;
                3'h2: c = CMD_PRECHARGE;
                3'h1: c = CMD_REFRESH;
                3'h0: c = CMD_MODE_LOAD;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : decode_command
endpackage : dram_core_pkg

// *** include/bank_if.sv ***
`timescale 1ns/1ps
interface bank_if;
    import dram_core_pkg::*;
    logic               activate;
    logic               precharge;
    logic               autoPreArm;
    logic [`ADDR_W-1:0] newRow;
    bank_state_type     state;
    logic [`ADDR_W-1:0] row;

    modport ctrl (output activate, output precharge, output autoPreArm, output newRow,
                  input state, input row);
    modport unit (input activate, input precharge, input autoPreArm, input newRow,
                  output state, output row);
endinterface : bank_if

// *** logic/bank_unit.sv ***
`timescale 1ns/1ps
module bank_unit
    import dram_core_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // command side
    bank_if.unit     link
);
    bank_state_type     state_q,     state_d;
    logic [`CNT_W-1:0]  count_q,     count_d;
    logic [`CNT_W-1:0]  rasCount_q,  rasCount_d;
    logic               apPending_q, apPending_d;
    logic [`ADDR_W-1:0] row_q,       row_d;

    always_comb begin
        state_d     = state_q;
        count_d     = count_q;
        rasCount_d  = rasCount_q;
        apPending_d = apPending_q | link.autoPreArm;
        row_d       = row_q;
        if (state_q != BANK_IDLE && rasCount_q != '1) begin
            rasCount_d = rasCount_q + `CNT_W'(1);
        end
        if (count_q != '0) begin
            count_d = count_q - `CNT_W'(1);
        end
        case (state_q)
            BANK_IDLE: begin
                // precharge here is a no-op
                if (link.activate) begin
                    state_d     = BANK_ACTIVATING;
                    count_d     = `CNT_W'(`ACTIVATE_CYCLES);
                    rasCount_d  = '0;
                    row_d       = link.newRow;
                    apPending_d = 1'b0;
                end
            end
            BANK_ACTIVATING: begin
                if (link.precharge) begin
                    state_d = BANK_PRECHARGING;
                    count_d = `CNT_W'(`ROW_PRECHARGE_CYCLES);
                end else if (count_q <= `CNT_W'(1)) begin
                    state_d = BANK_ACTIVE;
                end
            end
            BANK_ACTIVE: begin
                // auto precharge waits for min row active time
                if (link.precharge || (apPending_q
                        && rasCount_q >= `CNT_W'(`MIN_ROW_ACTIVE_CYCLES))) begin
                    state_d     = BANK_PRECHARGING;
                    count_d     = `CNT_W'(`ROW_PRECHARGE_CYCLES);
                    apPending_d = 1'b0;
                end
            end
            BANK_PRECHARGING: begin
                // repeated precharge ignored idle after delay
                if (count_q <= `CNT_W'(1)) begin
                    state_d = BANK_IDLE;
                end
            end
            default: state_d = BANK_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q     <= BANK_IDLE;
            count_q     <= '0;
            rasCount_q  <= '0;
            apPending_q <= 1'b0;
            row_q       <= '0;
        end else begin
            state_q     <= state_d;
            count_q     <= count_d;
            rasCount_q  <= rasCount_d;
            apPending_q <= apPending_d;
            row_q       <= row_d;
        end
    end

    assign link.state = state_q;
    assign link.row   = row_q;
endmodule : bank_unit

// *** logic/dram_command_core.sv ***
`timescale 1ns/1ps
module dram_command_core
    import dram_core_pkg::*;
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rstn,
    // link pins
    input  wire logic                memClk,
    input  wire logic                clockEnable,
    input  wire logic                chipSelectN,
    input  wire logic                rowStrobeN,
    input  wire logic                columnStrobeN,
    input  wire logic                writeEnableN,
    input  wire logic                bankSelectBit0,
    input  wire logic                bankSelectBit1,
    input  wire logic [`ADDR_W-1:0]  address,
    input  wire logic [`MASK_W-1:0]  writeByteMask,
    input  wire logic [`DATA_W-1:0]  dataIn,
    output wire logic [`DATA_W-1:0]  dataOut,
    output wire logic                dataOe,
    // status
    output wire logic [`ADDR_W-1:0]  modeRegister,
    output wire logic [`ADDR_W-1:0]  extModeRegister,
    output wire logic                dllEnable,
    output wire logic                dllReset,
    output wire logic                terminationEnable,
    output wire logic                selfRefreshActive,
    output wire logic                refreshPulse,
    output wire logic [`ADDR_W-1:0]  refreshRow,
    output wire logic [`BANK_COUNT-1:0] openBanks,
    output wire logic                illegalCommand
);
    pin_sample_type          sync1_q, sync2_q, pin;
    logic                    ckPrev_q;
    logic                    ckRise;
    logic [`DATA_W-1:0]      memory [`MEM_DEPTH];

    logic [`ADDR_W-1:0]      modeReg_q,    modeReg_d;
    logic [`ADDR_W-1:0]      extModeReg_q, extModeReg_d;
    logic [`CNT_W-1:0]       modeCount_q,  modeCount_d;
    logic                    selfRef_q,    selfRef_d;
    logic                    dllEn_q,      dllEn_d;
    logic                    dllRst_q,     dllRst_d;
    logic                    termEn_q,     termEn_d;
    logic                    refPulse_q,   refPulse_d;
    logic [`ADDR_W-1:0]      refRow_q,     refRow_d;
    logic [`CNT_W-1:0]       srTimer_q,    srTimer_d;
    burst_type               burstKind_q,  burstKind_d;
    logic [`BANK_W-1:0]      burstBank_q,  burstBank_d;
    logic [`COL_W-1:0]       burstCol_q,   burstCol_d;
    logic [`BANK_W-1:0]      beat_q,       beat_d;
    logic                    burstAp_q,    burstAp_d;
    logic                    illegal_q,    illegal_d;
    logic [`DATA_W-1:0]      dqOut_q,      dqOut_d;
    logic                    dqOe_q,       dqOe_d;

    cmd_type                 cmd;
    logic [`BANK_W-1:0]      bank;
    logic                    allIdle;
    logic                    memWrite;
    logic [`BANK_W+`COL_W-1:0] memIdx;
    logic [`BANK_COUNT-1:0]  actReq, preReq, apArm;
    bank_state_type          bankState [`BANK_COUNT];

    bank_if bankLink [`BANK_COUNT] ();

    for (genvar g = 0; g < `BANK_COUNT; g++) begin : g_bank
        assign bankLink[g].activate   = actReq[g];
        assign bankLink[g].precharge  = preReq[g];
        assign bankLink[g].autoPreArm = apArm[g];
        assign bankLink[g].newRow     = pin.addr;
        assign bankState[g]           = bankLink[g].state;
        assign openBanks[g]           = (bankLink[g].state == BANK_ACTIVE);
        bank_unit u_bank (
            .clock (clock),
            .rstn  (rstn),
            .link  (bankLink[g])
        );
    end

    assign pin    = sync2_q;
    assign ckRise = pin.ck & ~ckPrev_q;

    always_comb begin
        cmd          = decode_command(pin.csN, pin.rasN, pin.casN, pin.weN);
        bank         = {pin.bank1, pin.bank0};
        allIdle      = 1'b1;
        for (int i = 0; i < `BANK_COUNT; i++) begin
            if (bankState[i] != BANK_IDLE) allIdle = 1'b0;
        end
        modeReg_d    = modeReg_q;
        extModeReg_d = extModeReg_q;
        modeCount_d  = modeCount_q;
        selfRef_d    = selfRef_q;
        dllEn_d      = dllEn_q;
        dllRst_d     = 1'b0;
        termEn_d     = termEn_q;
        refPulse_d   = 1'b0;
        refRow_d     = refRow_q;
        srTimer_d    = srTimer_q;
        burstKind_d  = burstKind_q;
        burstBank_d  = burstBank_q;
        burstCol_d   = burstCol_q;
        beat_d       = beat_q;
        burstAp_d    = burstAp_q;
        illegal_d    = 1'b0;
        dqOut_d      = dqOut_q;
        dqOe_d       = dqOe_q;
        actReq       = '0;
        preReq       = '0;
        apArm        = '0;
        memWrite     = 1'b0;
        memIdx       = {burstBank_q, burstCol_q + `COL_W'(beat_q)};
        if (modeCount_q != '0) begin
            modeCount_d = modeCount_q - `CNT_W'(1);
        end
        if (selfRef_q) begin
            // only clock enable is watched here
            if (srTimer_q <= `CNT_W'(1)) begin
                srTimer_d  = `CNT_W'(`SELF_REFRESH_CYCLES);
                refRow_d   = refRow_q + `ADDR_W'(1);
                refPulse_d = 1'b1;
            end else begin
                srTimer_d = srTimer_q - `CNT_W'(1);
            end
            if (pin.cke) begin
                selfRef_d = 1'b0;
                dllEn_d   = 1'b1;
                dllRst_d  = 1'b1;
                termEn_d  = 1'b1;
            end
        end else if (ckRise) begin
            if (burstKind_q != BURST_NONE) begin
                if (burstKind_q == BURST_WRITE) begin
                    memWrite = 1'b1;
                end else begin
                    dqOut_d = memory[memIdx];
                end
                beat_d = beat_q + `BANK_W'(1);
                if (beat_q == `BANK_W'(`BURST_LEN - 1)) begin
                    burstKind_d = BURST_NONE;
                    dqOe_d      = 1'b0;
                    apArm[burstBank_q] = burstAp_q;
                end
            end
            if (modeCount_q != '0 && cmd != CMD_NOP) begin
                illegal_d = 1'b1;
            end else begin
                case (cmd)
                    CMD_NOP: begin
                        // nothing new accepted
                    end
                    CMD_MODE_LOAD: begin
                        if (!allIdle) begin
                            illegal_d = 1'b1;
                        end else if (bank == `MODE_SEL_MAIN) begin
                            modeReg_d   = pin.addr;
                            modeCount_d = `CNT_W'(`MODE_LOAD_CYCLES);
                        end else if (bank == `MODE_SEL_EXT) begin
                            extModeReg_d = pin.addr;
                            modeCount_d  = `CNT_W'(`MODE_LOAD_CYCLES);
                        end else begin
                            illegal_d = 1'b1;
                        end
                    end
                    CMD_ACTIVATE: begin
                        if (bankState[bank] != BANK_IDLE) begin
                            illegal_d = 1'b1;
                        end else begin
                            actReq[bank] = 1'b1;
                        end
                    end
                    CMD_READ, CMD_WRITE: begin
                        if (bankState[bank] != BANK_ACTIVE) begin
                            illegal_d = 1'b1;
                        end else begin
                            burstKind_d = (cmd == CMD_READ) ? BURST_READ : BURST_WRITE;
                            burstBank_d = bank;
                            burstCol_d  = {pin.addr[`COL_HIGH_BIT],
                                           pin.addr[`COL_LOW_TOP:0]};
                            burstAp_d   = pin.addr[`PRECHARGE_MODE_BIT];
                            beat_d      = '0;
                            dqOe_d      = (cmd == CMD_READ);
                        end
                    end
                    CMD_PRECHARGE: begin
                        if (pin.addr[`PRECHARGE_MODE_BIT]) begin
                            preReq = '1;
                        end else begin
                            preReq[bank] = 1'b1;
                        end
                    end
                    CMD_REFRESH: begin
                        if (!allIdle) begin
                            illegal_d = 1'b1;
                        end else if (pin.cke) begin
                            refRow_d   = refRow_q + `ADDR_W'(1);
                            refPulse_d = 1'b1;
                        end else begin
                            selfRef_d = 1'b1;
                            dllEn_d   = 1'b0;
                            termEn_d  = 1'b0;
                            srTimer_d = `CNT_W'(`SELF_REFRESH_CYCLES);
                            burstKind_d = BURST_NONE;
                            dqOe_d    = 1'b0;
                        end
                    end
                    default: illegal_d = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            // pins idle high, so no false link edge after reset
            sync1_q      <= '1;
            sync2_q      <= '1;
            ckPrev_q     <= 1'b1;
            modeReg_q    <= '0;
            extModeReg_q <= '0;
            modeCount_q  <= '0;
            selfRef_q    <= 1'b0;
            dllEn_q      <= 1'b1;
            dllRst_q     <= 1'b0;
            termEn_q     <= 1'b1;
            refPulse_q   <= 1'b0;
            refRow_q     <= '0;
            srTimer_q    <= '0;
            burstKind_q  <= BURST_NONE;
            burstBank_q  <= '0;
            burstCol_q   <= '0;
            beat_q       <= '0;
            burstAp_q    <= 1'b0;
            illegal_q    <= 1'b0;
            dqOut_q      <= '0;
            dqOe_q       <= 1'b0;
        end else begin
            sync1_q      <= {memClk, clockEnable, chipSelectN, rowStrobeN, columnStrobeN,
                             writeEnableN, bankSelectBit1, bankSelectBit0, address,
                             dataIn, writeByteMask};
            sync2_q      <= sync1_q;
            ckPrev_q     <= sync2_q.ck;
            modeReg_q    <= modeReg_d;
            extModeReg_q <= extModeReg_d;
            modeCount_q  <= modeCount_d;
            selfRef_q    <= selfRef_d;
            dllEn_q      <= dllEn_d;
            dllRst_q     <= dllRst_d;
            termEn_q     <= termEn_d;
            refPulse_q   <= refPulse_d;
            refRow_q     <= refRow_d;
            srTimer_q    <= srTimer_d;
            burstKind_q  <= burstKind_d;
            burstBank_q  <= burstBank_d;
            burstCol_q   <= burstCol_d;
            beat_q       <= beat_d;
            burstAp_q    <= burstAp_d;
            illegal_q    <= illegal_d;
            dqOut_q      <= dqOut_d;
            dqOe_q       <= dqOe_d;
        end
    end

    // byte-lane masked array write
    always_ff @(posedge clock) begin
        if (memWrite) begin
            for (int i = 0; i < `MASK_W; i++) begin
                if (!pin.mask[i]) begin
                    memory[memIdx][i*`BYTE_W +: `BYTE_W] <= pin.dq[i*`BYTE_W +: `BYTE_W];
                end
            end
        end
    end

    assign dataOut           = dqOut_q;
    assign dataOe            = dqOe_q;
    assign modeRegister      = modeReg_q;
    assign extModeRegister   = extModeReg_q;
    assign dllEnable         = dllEn_q;
    assign dllReset          = dllRst_q;
    assign terminationEnable = termEn_q;
    assign selfRefreshActive = selfRef_q;
    assign refreshPulse      = refPulse_q;
    assign refreshRow        = refRow_q;
    assign illegalCommand    = illegal_q;
endmodule : dram_command_core

// *** testbench/dram_core_props.sv ***
`timescale 1ns/1ps
module dram_core_props
    import dram_core_pkg::*;
(
    // clock and reset
    input wire logic                   clock,
    input wire logic                   rstn,
    // watched pins
    input wire logic                   chipSelectN,
    input wire logic                   dataOe,
    input wire logic [`ADDR_W-1:0]     modeRegister,
    input wire logic [`ADDR_W-1:0]     extModeRegister,
    input wire logic                   dllEnable,
    input wire logic                   dllReset,
    input wire logic                   terminationEnable,
    input wire logic                   selfRefreshActive,
    input wire logic                   refreshPulse,
    input wire logic [`ADDR_W-1:0]     refreshRow,
    input wire logic [`BANK_COUNT-1:0] openBanks,
    input wire logic                   illegalCommand
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_sr_dll_off: assert property (selfRefreshActive |-> !dllEnable && !terminationEnable)
        else $error("dll or termination on in self refresh");
    chk_sr_exit_on: assert property ($fell(selfRefreshActive) |-> ##[0:1] (dllReset && dllEnable && terminationEnable))
        else $error("self refresh exit without dll reset");
    chk_row_step: assert property ($rose(refreshPulse) |=> refreshRow == $past(refreshRow, 2) + 12'h001)
        else $error("refresh row did not step by one");
    chk_sr_frozen: assert property (selfRefreshActive && $past(selfRefreshActive) |-> $stable(modeRegister) && $stable(openBanks))
        else $error("state changed in self refresh");
    chk_sr_quiet: assert property (selfRefreshActive |-> !dataOe && !illegalCommand)
        else $error("activity in self refresh");
    chk_mode_idle: assert property (openBanks != 4'h0 |-> $stable(modeRegister) && $stable(extModeRegister))
        else $error("mode changed with a bank open");
    chk_refresh_idle: assert property (refreshPulse |-> openBanks == 4'h0)
        else $error("refresh with a bank open");
    chk_deselect_quiet: assert property (chipSelectN [*8] |=> !illegalCommand)
        else $error("deselect flagged a command");
endmodule : dram_core_props

// *** testbench/mem_controller_model.sv ***
`timescale 1ns/1ps
module mem_controller_model
    import dram_core_pkg::*;
(
    // clock
    input wire logic                clock,
    // command pins
    output logic                    memClk,
    output logic                    clockEnable,
    output logic                    chipSelectN,
    output logic                    rowStrobeN,
    output logic                    columnStrobeN,
    output logic                    writeEnableN,
    output logic                    bankSelectBit0,
    output logic                    bankSelectBit1,
    output logic [`ADDR_W-1:0]      address,
    // data pins
    output logic [`MASK_W-1:0]      writeByteMask,
    output logic [`DATA_W-1:0]      dataIn,
    input wire logic [`DATA_W-1:0]  dataOut
);
    initial begin
        {memClk, clockEnable, chipSelectN, rowStrobeN, columnStrobeN, writeEnableN} = 6'h3F;
        {bankSelectBit1, bankSelectBit0, address, writeByteMask, dataIn} = '0;
    end

    // one link period: pins change at the fall, held across the rise
    task automatic beat(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                        input logic cke, input logic drv, input logic [35:0] dm,
                        output logic [31:0] seen);
        @(posedge clock);
        #1;
        memClk = 1'b0;
        clockEnable = cke;
        {chipSelectN, rowStrobeN, columnStrobeN, writeEnableN} = c;
        {bankSelectBit1, bankSelectBit0, address} = {b, a};
        {writeByteMask, dataIn} = drv ? dm : ~{writeByteMask, dataIn};
        repeat (4) @(posedge clock);
        #1;
        seen = dataOut;
        memClk = 1'b1;
        repeat (3) @(posedge clock);
    endtask : beat
endmodule : mem_controller_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t %0h %0h", $time, g, e); end end
module tb;
    import dram_core_pkg::*;
    localparam logic [3:0] cmdAct = 4'h3, cmdRead = 4'h5, cmdWrite = 4'h4, cmdPre = 4'h2;
    localparam logic [3:0] cmdRef = 4'h1, cmdMode = 4'h0, cmdNop = 4'h7, cmdDesel = 4'hB;
    logic        clock, rstn, memClk, clockEnable, chipSelectN, rowStrobeN, columnStrobeN;
    logic        writeEnableN, bankSelectBit0, bankSelectBit1, dataOe, dllEnable, dllReset;
    logic        terminationEnable, selfRefreshActive, refreshPulse, illegalCommand;
    logic [11:0] address, modeRegister, extModeRegister, refreshRow, op, r0;
    logic [3:0]  writeByteMask, openBanks, openExp;
    logic [31:0] dataIn, dataOut, seen, w, rdq[$], mem[int];
    logic [8:0]  col;
    int          fails, comparisons, illCnt, illExp, cycles;

    dram_command_core i_dram_command_core (.clock, .rstn, .memClk, .clockEnable, .chipSelectN,
        .rowStrobeN, .columnStrobeN, .writeEnableN, .bankSelectBit0, .bankSelectBit1, .address,
        .writeByteMask, .dataIn, .dataOut, .dataOe, .modeRegister, .extModeRegister, .dllEnable,
        .dllReset, .terminationEnable, .selfRefreshActive, .refreshPulse, .refreshRow,
        .openBanks, .illegalCommand);
    mem_controller_model i_mem_controller_model (.clock, .memClk, .clockEnable, .chipSelectN,
        .rowStrobeN, .columnStrobeN, .writeEnableN, .bankSelectBit0, .bankSelectBit1, .address,
        .writeByteMask, .dataIn, .dataOut);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (illegalCommand === 1'b1) illCnt++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic cke = 1'b1);
        i_mem_controller_model.beat(c, b, a, cke, 1'b0, 36'h0, seen);
    endtask : cmd

    task automatic checkOpen();
        cmd(cmdNop, 2'h0, 12'h000);
        `CHK(openBanks, openExp)
        `CHK(illCnt, illExp)
    endtask : checkOpen

    task automatic wr(input logic [1:0] b, input logic [8:0] c, input logic ap, input logic rnd);
        logic [35:0] dm;
        cmd(cmdWrite, b, {2'h0, c[8], ap, c[7:0]});
        for (int k = 0; k < 4; k++) begin
            dm = {rnd ? 4'($urandom) : 4'h0, 32'($urandom)};
            i_mem_controller_model.beat(cmdNop, b, 12'h000, 1'b1, 1'b1, dm, seen);
            for (int y = 0; y < 4; y++) if (!dm[32 + y]) mem[{b, 9'(c + k)}][8*y +: 8] = dm[8*y +: 8];
        end
    endtask : wr

    task automatic rd(input logic [1:0] b, input logic [8:0] c, input logic ap);
        cmd(cmdRead, b, {2'h0, c[8], ap, c[7:0]});
        for (int k = 0; k < 4; k++) rdq.push_back(mem[{b, 9'(c + k)}]);
        cmd(cmdNop, b, 12'h000);
        while (rdq.size() > 0) begin
            cmd(cmdNop, b, 12'h000);
            w = rdq.pop_front();
            `CHK(seen, w)
        end
    endtask : rd

    initial begin
        rstn = 1'b0;
        openExp = 4'h0;
        void'($urandom(81));
        repeat (12) @(posedge clock);
        #1;
        `CHK({dllEnable, terminationEnable, openBanks, selfRefreshActive}, 7'h60)
        rstn = 1'b1;
        op = 12'($urandom);
        cmd(cmdMode, 2'h0, op);
        cmd(cmdMode, 2'h1, ~op);
        cmd(cmdMode, 2'h2, 12'h5A5);
        illExp = 1;
        checkOpen();
        `CHK({modeRegister, extModeRegister}, {op, ~op})
        for (int b = 0; b < 4; b++) cmd(cmdAct, 2'(b), 12'($urandom));
        cmd(cmdAct, 2'h2, 12'h000);
        cmd(cmdMode, 2'h0, ~op);
        illExp = 3;
        openExp = 4'hF;
        checkOpen();
        `CHK(modeRegister, op)
        col = 9'($urandom) & 9'h1FC;
        wr(2'h1, col, 1'b0, 1'b0);
        wr(2'h1, col, 1'b0, 1'b1);
        rd(2'h1, col, 1'b0);
        checkOpen();
        wr(2'h2, col, 1'b1, 1'b0);
        openExp = 4'hB;
        checkOpen();
        rd(2'h1, col, 1'b1);
        openExp = 4'h9;
        checkOpen();
        cmd(cmdPre, 2'h2, 12'h000);
        cmd(cmdPre, 2'h0, 12'h000);
        openExp = 4'h8;
        checkOpen();
        cmd(cmdRead, 2'h0, 12'h000);
        cmd(cmdDesel, 2'h0, 12'h000);
        illExp = 4;
        checkOpen();
        cmd(cmdPre, 2'h0, 12'h100);
        openExp = 4'h0;
        checkOpen();
        r0 = refreshRow;
        cmd(cmdRef, 2'h3, 12'($urandom));
        checkOpen();
        `CHK(refreshRow, r0 + 12'h001)
        cmd(cmdRef, 2'h0, 12'h000, 1'b0);
        cmd(cmdAct, 2'h1, 12'h000, 1'b0);
        `CHK({selfRefreshActive, dllEnable, terminationEnable}, 3'h4)
        cmd(cmdNop, 2'h0, 12'h000);
        checkOpen();
        `CHK({selfRefreshActive, dllEnable, terminationEnable}, 3'h3)
        give_verdict();
    end
endmodule : tb

bind dram_command_core dram_core_props i_props (.clock, .rstn, .chipSelectN, .dataOe,
    .modeRegister, .extModeRegister, .dllEnable, .dllReset, .terminationEnable,
    .selfRefreshActive, .refreshPulse, .refreshRow, .openBanks, .illegalCommand);
